// ### pkg/fdp_pkg.sv
// fdp_pkg: register map, field positions, reset values and timing
// constants for the floppy drive port control block.
// assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
package fdp_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CLK_NS          = 1_000_000_000 / CLK_HZ;
  // fixed-width read pulse per one-shot stage, in ns
  localparam int unsigned SHOT1_NS        = 200;
  localparam int unsigned SHOT2_NS        = 200;
  localparam logic [3:0]  SHOT1_CYC       = 4'((SHOT1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  SHOT2_CYC       = 4'((SHOT2_NS + CLK_NS - 1) / CLK_NS);

  // ------------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] SEL_LAMP_OFS  = 8'h00;
  localparam logic [7:0] SHARED_OFS    = 8'h04;
  localparam logic [7:0] DRV_STAT_OFS  = 8'h08;
  localparam logic [7:0] HOST_OFS      = 8'h0c;
  localparam logic [7:0] PULSE_OFS     = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h18;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  // SEL_LAMP: [2:0] drive number (0 none, 1..4), [7:4] lamp on, [11:8] flash
  localparam int unsigned SEL_NUM_LSB  = 0;
  localparam int unsigned LAMP_LSB     = 4;
  localparam int unsigned FLASH_LSB    = 8;
  // SHARED: side, head load, step dir, precomp, write enable
  localparam int unsigned SH_SIDE      = 0;
  localparam int unsigned SH_HEAD      = 1;
  localparam int unsigned SH_STEPDIR   = 2;
  localparam int unsigned SH_PRECOMP   = 3;
  localparam int unsigned SH_WREN      = 4;
  // HOST: bit0 init latched, bit1 parity error, bit2 xfer request,
  //       bit3 cable reversed
  localparam int unsigned HS_INIT      = 0;
  localparam int unsigned HS_PAR       = 1;
  localparam int unsigned HS_XFER      = 2;
  localparam int unsigned HS_REV       = 3;
  // PULSE (write-one strobes): bit0 pulser clear, bit1 force parity err,
  //   bit2 force init, bit3 shift clear, bit4 set xfer request
  localparam int unsigned PU_CLEAR     = 0;
  localparam int unsigned PU_FPAR      = 1;
  localparam int unsigned PU_FINIT     = 2;
  localparam int unsigned PU_SCLR      = 3;
  localparam int unsigned PU_XSET      = 4;
  // IRQ: bit0 host init, bit1 index, bit2 cable reversed, bit3 parity
  localparam int unsigned IRQ_W        = 4;

  // ------------------------------------------------------------------
  // reset values and misc
  // ------------------------------------------------------------------
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
  localparam int unsigned FLASH_BIT    = 21; // ~0.2 s blink at 10 MHz

  // drive status as seen on the cable, active high inside the block
  typedef struct packed {
    logic index_sense;
    logic protect_switch_two;
    logic protect_switch_one;
    logic disk_changed;
    logic track_zero_sense;
    logic drive_ready;
    logic disk_protect;
  } fdp_status_t;

  // shared, time-multiplexed control lines
  typedef struct packed {
    logic precomp;
    logic step_direction;
    logic head_load;
    logic side_select;
  } fdp_shared_t;

endpackage

// ### hw/fdp_port_ctrl.sv
// fdp_port_ctrl: controller-side drive cable logic with AXI4-Lite regs.
// assumes cable inputs already inverted to active high and synchronous
// to CLK; open-collector drivers live outside and invert the outputs.
`timescale 1ns/100ps
module fdp_port_ctrl
  import fdp_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RST,
  // axi4-lite slave
  input  wire logic [7:0]        S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [7:0]        S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // drive cable
  output logic [3:0]             DRIVE_SELECT,
  output logic [3:0]             DOOR_LAMP,
  output fdp_pkg::fdp_shared_t   SHARED_CTRL,
  output logic                   WRITE_GATE,
  output logic                   WRITE_DATA,
  input  wire fdp_pkg::fdp_status_t DRIVE_STATUS,
  input  wire logic              READ_DATA,
  input  wire logic              PRECOMP_SENSE,
  // bit sequencer, serial path, pll
  input  wire logic              SEQ_WRITE_GATE,
  input  wire logic              SERIAL_WRITE_DATA,
  output logic                   SEQ_INDEX_TEST,
  output logic                   SEQ_RAW_PULSE_TEST,
  output logic                   PLL_READ_PULSE,
  // host interface side
  input  wire logic              HOST_INIT,
  input  wire logic              IFACE_HAS_DATA,
  input  wire logic              PARITY_FAULT,
  output logic                   SHIFT_RESET,
  output logic                   XFER_REQUEST,
  output logic                   IRQ
);
  import fdp_pkg::*;

  // ------------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------------
  logic        aw_held_r, w_held_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_go;
  logic        rd_go;
  logic [31:0] rd_word;
  logic        rd_hit;

  assign wr_go = aw_held_r && w_held_r && !S_AXI_BVALID;
  assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_r     <= 1'b1;
        aw_addr_r     <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_r     <= 1'b1;
        w_data_r     <= S_AXI_WDATA;
        w_strb_r     <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_go) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (aw_addr_r <= IRQ_MASK_OFS && aw_addr_r[1:0] == 2'b00)
                        ? RESP_OKAY : RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // only byte lane 0 and 1 carry fields; lane strobes gate the write
  logic wr_sel, wr_sh, wr_pu, wr_ist, wr_imk;
  assign wr_sel = wr_go && aw_addr_r == SEL_LAMP_OFS;
  assign wr_sh  = wr_go && aw_addr_r == SHARED_OFS   && w_strb_r[0];
  assign wr_pu  = wr_go && aw_addr_r == PULSE_OFS    && w_strb_r[0];
  assign wr_ist = wr_go && aw_addr_r == IRQ_STAT_OFS && w_strb_r[0];
  assign wr_imk = wr_go && aw_addr_r == IRQ_MASK_OFS && w_strb_r[0];

  logic pulser_clear, force_par, force_init, shift_clear_pulse, xfer_set;
  assign pulser_clear      = wr_pu && w_data_r[PU_CLEAR];
  assign force_par         = wr_pu && w_data_r[PU_FPAR];
  assign force_init        = wr_pu && w_data_r[PU_FINIT];
  assign shift_clear_pulse = wr_pu && w_data_r[PU_SCLR];
  assign xfer_set          = wr_pu && w_data_r[PU_XSET];

  // ------------------------------------------------------------------
  // select and lamp port
  // ------------------------------------------------------------------
  logic [2:0] drive_num_r;
  logic [3:0] lamp_r, flash_r;
  logic [FLASH_BIT:0] blink_r;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      drive_num_r <= 3'h0;
      lamp_r      <= 4'h0;
      flash_r     <= 4'h0;
    end else if (wr_sel) begin
      if (w_strb_r[0]) begin
        drive_num_r <= w_data_r[SEL_NUM_LSB +: 3];
        lamp_r      <= w_data_r[LAMP_LSB +: 4];
      end
      if (w_strb_r[1])
        flash_r <= w_data_r[FLASH_LSB +: 4];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      blink_r <= '0;
    else
      blink_r <= blink_r + 1'b1;
  end

  // one-hot decode: number 1..4 picks one line, anything else none
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      DRIVE_SELECT <= 4'h0;
      DOOR_LAMP    <= 4'h0;
    end else begin
      unique case (drive_num_r)
        3'h1:    DRIVE_SELECT <= 4'h1;
        3'h2:    DRIVE_SELECT <= 4'h2;
        3'h3:    DRIVE_SELECT <= 4'h4;
        3'h4:    DRIVE_SELECT <= 4'h8;
        default: DRIVE_SELECT <= 4'h0;
      endcase
      // error flash blinks the faulting drive's door lamp
      DOOR_LAMP <= (lamp_r & ~flash_r)
                 | (flash_r & {4{blink_r[FLASH_BIT]}});
    end
  end

  // ------------------------------------------------------------------
  // shared port and write path
  // ------------------------------------------------------------------
  logic [4:0] shared_r;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      shared_r <= 5'h00;
    else if (wr_sh)
      shared_r <= w_data_r[4:0];
  end

  // shared lines only mean something to the selected drive, so they are
  // driven as-is; the drives do the qualifying
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SHARED_CTRL <= '0;
      WRITE_GATE  <= 1'b0;
      WRITE_DATA  <= 1'b0;
    end else begin
      SHARED_CTRL.side_select    <= shared_r[SH_SIDE];
      SHARED_CTRL.head_load      <= shared_r[SH_HEAD];
      SHARED_CTRL.step_direction <= shared_r[SH_STEPDIR];
      SHARED_CTRL.precomp        <= shared_r[SH_PRECOMP];
      WRITE_GATE <= shared_r[SH_WREN] && SEQ_WRITE_GATE;
      WRITE_DATA <= SERIAL_WRITE_DATA;
    end
  end

  // ------------------------------------------------------------------
  // read pulse shaping
  // ------------------------------------------------------------------
  logic       rd_prev_r;
  logic [3:0] shot1_r, shot2_r;
  logic       shot1_end;
  assign shot1_end = shot1_r == 4'h1;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rd_prev_r <= 1'b0;
      shot1_r   <= 4'h0;
      shot2_r   <= 4'h0;
    end else begin
      rd_prev_r <= READ_DATA;
      // stage one triggers on the rising edge, stage two on stage one end
      if (READ_DATA && !rd_prev_r && shot1_r == 4'h0)
        shot1_r <= SHOT1_CYC;
      else if (shot1_r != 4'h0)
        shot1_r <= shot1_r - 4'h1;
      if (shot1_end)
        shot2_r <= SHOT2_CYC;
      else if (shot2_r != 4'h0)
        shot2_r <= shot2_r - 4'h1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PLL_READ_PULSE     <= 1'b0;
      SEQ_RAW_PULSE_TEST <= 1'b0;
      SEQ_INDEX_TEST     <= 1'b0;
    end else begin
      PLL_READ_PULSE     <= shot2_r != 4'h0;
      SEQ_RAW_PULSE_TEST <= shot2_r != 4'h0;
      SEQ_INDEX_TEST     <= DRIVE_STATUS.index_sense;
    end
  end

  // ------------------------------------------------------------------
  // host interface flags
  // ------------------------------------------------------------------
  logic init_prev_r, init_latch_r, par_err_r, xfer_r, rev_r;
  logic host_rd;
  assign host_rd = rd_go && S_AXI_ARADDR == HOST_OFS;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      init_prev_r  <= 1'b0;
      init_latch_r <= 1'b0;
    end else begin
      init_prev_r <= HOST_INIT;
      // a new edge wins over the read or the clear in the same cycle
      if ((HOST_INIT && !init_prev_r) || force_init)
        init_latch_r <= 1'b1;
      else if (pulser_clear || host_rd)
        init_latch_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      par_err_r <= 1'b0;
    else if (PARITY_FAULT || force_par)
      par_err_r <= 1'b1;
    else if (pulser_clear)
      par_err_r <= 1'b0;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      xfer_r <= 1'b0;
    else if (xfer_set)
      xfer_r <= 1'b1;
    else if (pulser_clear || IFACE_HAS_DATA || shift_clear_pulse)
      xfer_r <= 1'b0;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rev_r        <= 1'b0;
      SHIFT_RESET  <= 1'b0;
      XFER_REQUEST <= 1'b0;
    end else begin
      rev_r        <= !PRECOMP_SENSE;
      SHIFT_RESET  <= pulser_clear || shift_clear_pulse;
      XFER_REQUEST <= xfer_r;
    end
  end

  // ------------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------------
  logic [IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_ev;
  logic             idx_prev_r, rev_prev_r, par_prev_r;

  assign irq_ev = {par_err_r && !par_prev_r,
                   rev_r && !rev_prev_r,
                   DRIVE_STATUS.index_sense && !idx_prev_r,
                   HOST_INIT && !init_prev_r};

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      idx_prev_r <= 1'b0;
      rev_prev_r <= 1'b0;
      par_prev_r <= 1'b0;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      IRQ        <= 1'b0;
    end else begin
      idx_prev_r <= DRIVE_STATUS.index_sense;
      rev_prev_r <= rev_r;
      par_prev_r <= par_err_r;
      // set wins over write-one-to-clear
      irq_stat_r <= (irq_stat_r & ~({IRQ_W{wr_ist}} & w_data_r[IRQ_W-1:0]))
                  | irq_ev;
      if (wr_imk)
        irq_mask_r <= w_data_r[IRQ_W-1:0];
      IRQ <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ------------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------------
  always_comb begin
    rd_word = RESET_WORD;
    rd_hit  = 1'b1;
    unique case (S_AXI_ARADDR)
      SEL_LAMP_OFS: rd_word = {20'h0, flash_r, lamp_r, 1'b0, drive_num_r};
      SHARED_OFS:   rd_word = {27'h0, shared_r};
      DRV_STAT_OFS: rd_word = {25'h0, DRIVE_STATUS};
      HOST_OFS:     rd_word = {28'h0, rev_r, xfer_r, par_err_r,
                               init_latch_r};
      PULSE_OFS:    rd_word = RESET_WORD;
      IRQ_STAT_OFS: rd_word = {28'h0, irq_stat_r};
      IRQ_MASK_OFS: rd_word = {28'h0, irq_mask_r};
      default:      rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= RESP_OKAY;
    end else if (rd_go) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_word;
      S_AXI_RRESP   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule // fdp_port_ctrl

// ### sim/fdp_checker.sv
// fdp_checker: concurrent checks on the cable, sequencer and host interface side of fdp_port_ctrl.
// assumes it is bound into fdp_port_ctrl and sees only its ports.
`timescale 1ns/100ps
module fdp_checker
  import fdp_pkg::*;
(
  input wire logic                 CLK,
  input wire logic                 RST,
  input wire logic [3:0]           DRIVE_SELECT,
  input wire logic                 WRITE_GATE,
  input wire logic                 WRITE_DATA,
  input wire fdp_pkg::fdp_status_t DRIVE_STATUS,
  input wire logic                 READ_DATA,
  input wire logic                 SEQ_WRITE_GATE,
  input wire logic                 SERIAL_WRITE_DATA,
  input wire logic                 SEQ_INDEX_TEST,
  input wire logic                 SEQ_RAW_PULSE_TEST,
  input wire logic                 PLL_READ_PULSE,
  input wire logic                 IFACE_HAS_DATA,
  input wire logic                 SHIFT_RESET,
  input wire logic                 XFER_REQUEST
);
  default clocking dcb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  chk_sel_onehot: assert property ($onehot0(DRIVE_SELECT))
    else $error("more than one drive selected");
  chk_wgate_cause: assert property (
    WRITE_GATE |-> $past(SEQ_WRITE_GATE))
    else $error("write gate without sequencer gate");
  // reset itself is the condition here, so it cannot also disable it
  chk_wgate_reset: assert property (
    disable iff (1'b0) RST |-> !WRITE_GATE)
    else $error("write gate high in reset");
  chk_wdata_copy: assert property (!$past(RST) |->
    WRITE_DATA == $past(SERIAL_WRITE_DATA))
    else $error("write data not one cycle behind serial path");
  chk_index_route: assert property (!$past(RST) |->
    SEQ_INDEX_TEST == $past(DRIVE_STATUS.index_sense))
    else $error("index not routed to sequencer");
  chk_shape_width: assert property ($rose(PLL_READ_PULSE) |->
    PLL_READ_PULSE [*2] ##1 !PLL_READ_PULSE)
    else $error("shaped pulse width wrong");
  chk_shape_cause: assert property ($rose(READ_DATA) |-> ##[2:6]
    PLL_READ_PULSE)
    else $error("read edge not shaped");
  chk_shape_pair: assert property (
    SEQ_RAW_PULSE_TEST == PLL_READ_PULSE)
    else $error("pll and sequencer pulses differ");
  chk_xfer_clear: assert property (
    IFACE_HAS_DATA |-> ##2 !XFER_REQUEST)
    else $error("transfer request survives data ready");
  chk_shift_pulse: assert property (SHIFT_RESET |=> !SHIFT_RESET)
    else $error("shift reset longer than one cycle");

  cover property ($rose(PLL_READ_PULSE));
  cover property ($fell(XFER_REQUEST));
  cover property (WRITE_GATE && SEQ_WRITE_GATE);
endmodule // fdp_checker

bind fdp_port_ctrl fdp_checker fdp_checker_inst (
  .CLK(CLK), .RST(RST), .DRIVE_SELECT(DRIVE_SELECT),
  .WRITE_GATE(WRITE_GATE), .WRITE_DATA(WRITE_DATA),
  .DRIVE_STATUS(DRIVE_STATUS), .READ_DATA(READ_DATA),
  .SEQ_WRITE_GATE(SEQ_WRITE_GATE), .SERIAL_WRITE_DATA(SERIAL_WRITE_DATA),
  .SEQ_INDEX_TEST(SEQ_INDEX_TEST), .SEQ_RAW_PULSE_TEST(SEQ_RAW_PULSE_TEST),
  .PLL_READ_PULSE(PLL_READ_PULSE), .IFACE_HAS_DATA(IFACE_HAS_DATA),
  .SHIFT_RESET(SHIFT_RESET), .XFER_REQUEST(XFER_REQUEST)
);

// ### sim/fdp_drive_chain.sv
// fdp_drive_chain: four daisy-chained drives on the shared cable.
// assumes active-high levels; unselected lines sit at pulled-up idle.
`timescale 1ns/100ps
module fdp_drive_chain
  import fdp_pkg::*;
(
  input  wire logic                 CLK,
  input  wire logic                 RST,
  input  wire logic [3:0]           DRIVE_SELECT,
  input  wire fdp_pkg::fdp_shared_t SHARED_CTRL,
  input  wire logic                 REVERSED,
  input  wire logic                 INDEX_KICK,
  input  wire logic                 READ_KICK,
  output fdp_pkg::fdp_status_t      DRIVE_STATUS,
  output logic                      READ_DATA,
  output logic                      PRECOMP_SENSE,
  output logic [3:0]                HEAD_LOADED
);
  // a drive takes the shared lines only while selected
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      HEAD_LOADED <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (DRIVE_SELECT[i]) begin
          HEAD_LOADED[i] <= SHARED_CTRL.head_load;
        end
      end
    end
  end
  // each drive reports its own pattern; idle lines read inactive
  always_comb begin
    DRIVE_STATUS = '0;
    for (int i = 0; i < 4; i++) begin
      if (DRIVE_SELECT[i]) begin
        DRIVE_STATUS = {INDEX_KICK, 4'(1 << i), 2'b01};
      end
    end
  end
  // reversed cable shorts the sensed line to ground
  assign PRECOMP_SENSE = !REVERSED;
  assign READ_DATA     = READ_KICK && (DRIVE_SELECT != 4'h0);
endmodule // fdp_drive_chain

// ### sim/fdp_port_ctrl_tb_top.sv
// fdp_port_ctrl_tb_top: register-level tests of the drive port block.
// assumes fdp_port_ctrl with bound checker and the drive chain model.
`timescale 1ns/100ps
module fdp_port_ctrl_tb_top;
  import fdp_pkg::*;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, wgate, wdat;
  logic rdd, psense, seq_wg, ser_wd, idx_t, raw_t, pll_p, host_init;
  logic iface, pfault, shreset, xfer, irq, reversed, idx_kick, rd_kick;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, cnt, cnt2, base;
  logic [31:0] shr_cnt = 32'h0;
  logic [1:0]  bresp, rresp;
  logic [3:0]  sel, lamp, loaded;
  logic        ia;
  fdp_shared_t shctl;
  fdp_status_t dstat;
  int          errors = 0;
  int          n_checks = 0;

  fdp_port_ctrl fdp_port_ctrl_inst (
    .CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .DRIVE_SELECT(sel), .DOOR_LAMP(lamp), .SHARED_CTRL(shctl),
    .WRITE_GATE(wgate), .WRITE_DATA(wdat), .DRIVE_STATUS(dstat),
    .READ_DATA(rdd), .PRECOMP_SENSE(psense), .SEQ_WRITE_GATE(seq_wg),
    .SERIAL_WRITE_DATA(ser_wd), .SEQ_INDEX_TEST(idx_t),
    .SEQ_RAW_PULSE_TEST(raw_t), .PLL_READ_PULSE(pll_p),
    .HOST_INIT(host_init), .IFACE_HAS_DATA(iface), .PARITY_FAULT(pfault),
    .SHIFT_RESET(shreset), .XFER_REQUEST(xfer), .IRQ(irq));
  fdp_drive_chain fdp_drive_chain_inst (
    .CLK(clk), .RST(rst), .DRIVE_SELECT(sel), .SHARED_CTRL(shctl),
    .REVERSED(reversed), .INDEX_KICK(idx_kick), .READ_KICK(rd_kick),
    .DRIVE_STATUS(dstat), .READ_DATA(rdd), .PRECOMP_SENSE(psense),
    .HEAD_LOADED(loaded));

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t mismatch got %h exp %h", $time, g, e);
    end
  endtask
  // waits have no limit of their own: the watchdog ends a hung transfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    cmp({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    cmp({30'h0, rresp}, {30'h0, er});
    if (er == RESP_OKAY) cmp(rdata, ed);
  endtask
  // k picks the pins to pulse: {host_init, pfault, iface}
  task automatic pulse_in(input logic [2:0] k);
    {host_init, pfault, iface} <= k;
    @(posedge clk);
    {host_init, pfault, iface} <= 3'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) shr_cnt <= shr_cnt + 32'(shreset);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata} = '0;
    {seq_wg, ser_wd, host_init, iface, pfault} = '0;
    {reversed, idx_kick, rd_kick} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(SEL_LAMP_OFS, 32'h0, RESP_OKAY);
    for (int n = 0; n < 8; n++) begin
      wr(SEL_LAMP_OFS, 32'(n | (n ^ 5) << LAMP_LSB), RESP_OKAY);
      repeat (2) @(posedge clk);
      cmp({28'h0, sel}, (n > 0 && n < 5) ? 32'h1 << (n - 1) : 0);
      cmp({28'h0, lamp}, 32'((n ^ 5) & 15));
    end
    // blink counter is far from bit FLASH_BIT, so flashing lamps are dark
    wr(SEL_LAMP_OFS, 32'h1f0, RESP_OKAY);
    repeat (2) @(posedge clk);
    cmp({28'h0, lamp}, 32'he);
    for (int n = 1; n < 5; n++) begin
      wr(SEL_LAMP_OFS, 32'(n), RESP_OKAY);
      rd(DRV_STAT_OFS, (32'h1 << (n + 1)) | 32'h1, RESP_OKAY);
    end
    wr(SEL_LAMP_OFS, 32'h2, RESP_OKAY);
    for (int b = 0; b < 4; b++) begin
      wr(SHARED_OFS, 32'h1 << b, RESP_OKAY);
      repeat (2) @(posedge clk);
      cmp({28'h0, shctl}, 32'h1 << b);
    end
    wr(SHARED_OFS, 32'h1 << SH_HEAD, RESP_OKAY);
    repeat (3) @(posedge clk);
    cmp({28'h0, loaded}, 32'h2);
    wr(SEL_LAMP_OFS, 32'h4, RESP_OKAY);
    idx_kick <= 1'b1;
    repeat (3) @(posedge clk);
    cmp({28'h0, loaded}, 32'ha);
    cmp({31'h0, idx_t}, 32'h1);
    rd(DRV_STAT_OFS, 32'h61, RESP_OKAY);
    idx_kick <= 1'b0;
    rd_kick <= 1'b1;
    @(posedge clk);
    rd_kick <= 1'b0;
    {cnt, cnt2} = '0;
    repeat (12) begin
      @(posedge clk);
      cnt = cnt + 32'(pll_p);
      cnt2 = cnt2 + 32'(raw_t);
    end
    cmp(cnt, 32'(SHOT2_CYC));
    cmp(cnt2, 32'(SHOT2_CYC));
    wr(SHARED_OFS, 32'h1 << SH_WREN, RESP_OKAY);
    seq_wg <= 1'b1;
    ser_wd <= 1'b1;
    repeat (3) @(posedge clk);
    cmp({30'h0, wgate, wdat}, 32'h3);
    seq_wg <= 1'b0;
    repeat (3) @(posedge clk);
    cmp({31'h0, wgate}, 32'h0);
    seq_wg <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b1;
    #10;
    cmp({31'h0, wgate}, 32'h0);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    {seq_wg, ser_wd} <= 2'b00;
    for (int v = 1; v >= 0; v--) begin
      reversed <= v[0];
      repeat (3) @(posedge clk);
      rd(HOST_OFS, 32'(v) << HS_REV, RESP_OKAY);
    end
    pulse_in(3'h4);
    rd(HOST_OFS, 32'h1, RESP_OKAY);
    rd(HOST_OFS, 32'h0, RESP_OKAY);
    wr(PULSE_OFS, 32'h16, RESP_OKAY);
    rd(HOST_OFS, 32'h7, RESP_OKAY);
    wr(PULSE_OFS, 32'h16, RESP_OKAY);
    base = shr_cnt;
    wr(PULSE_OFS, 32'h1 << PU_CLEAR, RESP_OKAY);
    repeat (3) @(posedge clk);
    cmp({31'h0, xfer}, 32'h0);
    cmp(shr_cnt, base + 1);
    rd(HOST_OFS, 32'h0, RESP_OKAY);
    pulse_in(3'h2);
    rd(HOST_OFS, 32'h1 << HS_PAR, RESP_OKAY);
    wr(PULSE_OFS, 32'h1 << PU_XSET, RESP_OKAY);
    repeat (2) @(posedge clk);
    cmp({31'h0, xfer}, 32'h1);
    pulse_in(3'h1);
    cmp({31'h0, xfer}, 32'h0);
    wr(PULSE_OFS, 32'h1 << PU_XSET, RESP_OKAY);
    base = shr_cnt;
    wr(PULSE_OFS, 32'h1 << PU_SCLR, RESP_OKAY);
    repeat (3) @(posedge clk);
    cmp({31'h0, xfer}, 32'h0);
    cmp(shr_cnt, base + 1);
    wr(IRQ_STAT_OFS, 32'hf, RESP_OKAY);
    wr(IRQ_MASK_OFS, 32'h0, RESP_OKAY);
    pulse_in(3'h4);
    rd(IRQ_STAT_OFS, 32'h1, RESP_OKAY);
    ia = irq;
    wr(IRQ_MASK_OFS, 32'hf, RESP_OKAY);
    repeat (2) @(posedge clk);
    cmp({30'h0, ia, irq}, 32'h1);
    wr(IRQ_STAT_OFS, 32'h1, RESP_OKAY);
    repeat (2) @(posedge clk);
    cmp({31'h0, irq}, 32'h0);
    wr(8'h1c, 32'h1, RESP_SLVERR);
    wr(8'h02, 32'h1, RESP_SLVERR);
    rd(8'h1c, 32'h0, RESP_SLVERR);
    rd(PULSE_OFS, 32'h0, RESP_OKAY);
    finish_test();
  end
endmodule // fdp_port_ctrl_tb_top
